/* hw/gated_timer_cfg.svh */
// register map, field positions, reset values and prescale counts
`ifndef GATED_TIMER_CFG_SVH
`define GATED_TIMER_CFG_SVH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define TMR_OFS_CONTROL   8'h00
`define TMR_OFS_COUNT     8'h04
`define TMR_OFS_PERIOD    8'h08
`define TMR_OFS_STATUS    8'h0c
`define TMR_OFS_MASK      8'h10

// ------------------------------------------------------------
// control field positions
// ------------------------------------------------------------
`define TMR_BIT_RUN       15
`define TMR_BIT_IDLE      13
`define TMR_BIT_GATE      6
`define TMR_BIT_PSC_HI    5
`define TMR_BIT_PSC_LO    4
`define TMR_BIT_PAIR      3
`define TMR_BIT_SRC       1
`define TMR_CONTROL_MASK  16'ha07a

// ------------------------------------------------------------
// status bits and reset values
// ------------------------------------------------------------
`define TMR_ST_MATCH      0
`define TMR_ST_GATE_FALL  1
`define TMR_CONTROL_RST   16'h0000
`define TMR_COUNT_RST     32'h0000_0000
`define TMR_PERIOD_RST    32'hffff_ffff
`define TMR_STATUS_RST    2'h0
`define TMR_MASK_RST      2'h0

// ------------------------------------------------------------
// prescaler terminal counts (ratio minus one)
// ------------------------------------------------------------
`define TMR_PSC_TERM_1    8'h00
`define TMR_PSC_TERM_8    8'h07
`define TMR_PSC_TERM_64   8'h3f
`define TMR_PSC_TERM_256  8'hff

`endif

/* hw/gated_timer_pkg.sv */
// types shared by the timer modules
package gated_timer_pkg;

    typedef enum logic [1:0] {
        PSC_DIV1   = 2'b00,
        PSC_DIV8   = 2'b01,
        PSC_DIV64  = 2'b10,
        PSC_DIV256 = 2'b11
    } prescale_type;

    typedef logic [1:0] status_type;

endpackage

/* hw/prescale_if.sv */
// carrier between timer control and its prescaler
`timescale 1ns/10ps
interface prescale_if;
    import gated_timer_pkg::*;

    logic         pulse;
    logic         clear;
    prescale_type select;
    logic         tick;

    modport ctrl   (output pulse, output clear, output select, input tick);
    modport scaler (input pulse, input clear, input select, output tick);
endinterface

/* hw/timer_prescaler.sv */
// input prescaler: passes one tick per 1, 8, 64 or 256 input pulses
`timescale 1ns/10ps
`include "gated_timer_cfg.svh"
module timer_prescaler (
    input  wire logic pclk,
    input  wire logic presetn,
    prescale_if.scaler psc
);
    import gated_timer_pkg::*;

    logic [7:0] psc_count;
    logic [7:0] term;

    always_comb begin
        case (psc.select)
            PSC_DIV1:   term = `TMR_PSC_TERM_1;
            PSC_DIV8:   term = `TMR_PSC_TERM_8;
            PSC_DIV64:  term = `TMR_PSC_TERM_64;
            PSC_DIV256: term = `TMR_PSC_TERM_256;
            default:    term = `TMR_PSC_TERM_1;
        endcase
    end

    assign psc.tick = psc.pulse && (psc_count >= term);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            psc_count <= 8'h00;
        end else if (psc.clear) begin
            psc_count <= 8'h00;
        end else if (psc.pulse) begin
            psc_count <= psc.tick ? 8'h00 : psc_count + 8'h01;
        end
    end
endmodule

/* hw/gated_timer_pair_control.sv */
// general-purpose timer with pairing, idle halt, prescaler and gated mode
//
// Summary of operation
// - In pairing mode the run bit starts and stops the combined 32-bit counter.
// - Outside pairing mode the run bit starts and stops the standalone 16-bit counter.
// - With idle halt set, all counting stops while the device is idle.
// - With idle halt clear, counting goes on while the device is idle.
// - With the external pin selected as source, the gate enable bit has no effect.
// - With the internal clock and gate enable set, the timer runs in gated accumulation mode.
// - The prescale field divides the selected input by 256, 64, 8 or 1 for codes 11, 10, 01, 00.
// - Setting pairing mode joins this timer and its neighbour into one 32-bit timer.
// - Clearing pairing mode leaves the lower 16 bits counting as a standalone 16-bit timer; the upper 16 bits hold their value.
// - With the source bit set, the timer counts rising edges of the external count pin.
// - With the source bit clear, the timer counts peripheral clocks.
`timescale 1ns/10ps
`include "gated_timer_cfg.svh"
module gated_timer_pair_control (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        device_idle,
    input  wire logic        ext_count_pin,
    output logic             timer_irq
);
    import gated_timer_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [15:0] timer_control;
    logic [31:0] count;
    logic [31:0] next_count;
    logic [31:0] period;
    status_type  status;
    status_type  next_status;
    status_type  mask;
    status_type  next_mask;
    status_type  read_status;
    logic        ext_meta;
    logic        ext_sync;
    logic        ext_prev;

    prescale_if psc_bus ();

    timer_prescaler u_prescaler (
        .pclk    (pclk),
        .presetn (presetn),
        .psc     (psc_bus.scaler)
    );

    // ------------------------------------------------------------
    // control fields
    // ------------------------------------------------------------
    logic timer_run;
    logic idle_halt;
    logic gate_accumulate_enable;
    logic wide_pair_mode;
    logic clock_source_select;
    logic gated_mode;
    logic count_enable;
    logic ext_rise;
    logic gate_fall;
    logic period_match;

    assign timer_run              = timer_control[`TMR_BIT_RUN];
    assign idle_halt              = timer_control[`TMR_BIT_IDLE];
    assign gate_accumulate_enable = timer_control[`TMR_BIT_GATE];
    assign wide_pair_mode         = timer_control[`TMR_BIT_PAIR];
    assign clock_source_select    = timer_control[`TMR_BIT_SRC];

    assign gated_mode   = !clock_source_select && gate_accumulate_enable;
    assign count_enable = timer_run && !(idle_halt && device_idle);
    assign ext_rise     = ext_sync && !ext_prev;
    assign gate_fall    = !ext_sync && ext_prev;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic setup_phase;
    logic access_done;
    logic wr_done;
    logic rd_done;
    logic addr_valid;
    logic wr_control;
    logic wr_count;
    logic wr_period;
    logic wr_mask;
    logic [31:0] read_mux;

    assign setup_phase = psel && !penable;
    assign access_done = psel && penable && pready;
    assign wr_done     = access_done && pwrite;
    assign rd_done     = access_done && !pwrite;
    assign addr_valid  = (paddr == `TMR_OFS_CONTROL) || (paddr == `TMR_OFS_COUNT) ||
                         (paddr == `TMR_OFS_PERIOD) || (paddr == `TMR_OFS_STATUS) ||
                         (paddr == `TMR_OFS_MASK);
    assign wr_control  = wr_done && (paddr == `TMR_OFS_CONTROL);
    assign wr_count    = wr_done && (paddr == `TMR_OFS_COUNT);
    assign wr_period   = wr_done && (paddr == `TMR_OFS_PERIOD);
    assign wr_mask     = wr_done && (paddr == `TMR_OFS_MASK);

    always_comb begin
        case (paddr)
            `TMR_OFS_CONTROL: read_mux = {16'h0000, timer_control};
            `TMR_OFS_COUNT:   read_mux = count;
            `TMR_OFS_PERIOD:  read_mux = period;
            `TMR_OFS_STATUS:  read_mux = {30'h0000_0000, status};
            `TMR_OFS_MASK:    read_mux = {30'h0000_0000, mask};
            default:          read_mux = 32'h0000_0000;
        endcase
    end

    // answer in the first access cycle, data captured at setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready      <= 1'b0;
            pslverr     <= 1'b0;
            prdata      <= 32'h0000_0000;
            read_status <= `TMR_STATUS_RST;
        end else begin
            pready      <= setup_phase;
            pslverr     <= setup_phase && !addr_valid;
            read_status <= `TMR_STATUS_RST;
            if (setup_phase) begin
                prdata <= pwrite ? 32'h0000_0000 : read_mux;
                if (!pwrite && (paddr == `TMR_OFS_STATUS)) begin
                    read_status <= status;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control <= `TMR_CONTROL_RST;
        end else if (wr_control) begin
            timer_control <= pwdata[15:0] & `TMR_CONTROL_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period <= `TMR_PERIOD_RST;
        end else if (wr_period) begin
            period <= pwdata;
        end
    end

    // interrupt output must see a mask write in the same edge
    assign next_mask = wr_mask ? pwdata[1:0] : mask;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= `TMR_MASK_RST;
        end else if (wr_mask) begin
            mask <= pwdata[1:0];
        end
    end

    // ------------------------------------------------------------
    // pin synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_meta <= 1'b0;
            ext_sync <= 1'b0;
            ext_prev <= 1'b0;
        end else begin
            ext_meta <= ext_count_pin;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // ------------------------------------------------------------
    // prescaler feed
    // ------------------------------------------------------------
    always_comb begin
        psc_bus.clear  = !timer_run;
        psc_bus.select = prescale_type'(timer_control[`TMR_BIT_PSC_HI:`TMR_BIT_PSC_LO]);
        if (!count_enable) begin
            psc_bus.pulse = 1'b0;
        end else if (clock_source_select) begin
            psc_bus.pulse = ext_rise;
        end else if (gated_mode) begin
            psc_bus.pulse = ext_sync;
        end else begin
            psc_bus.pulse = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_comb begin
        next_count   = count;
        period_match = 1'b0;
        if (wr_count) begin
            next_count = pwdata;
        end else if (psc_bus.tick) begin
            if (wide_pair_mode) begin
                if (count == period) begin
                    next_count   = 32'h0000_0000;
                    period_match = 1'b1;
                end else begin
                    next_count = count + 32'h0000_0001;
                end
            end else if (count[15:0] == period[15:0]) begin
                next_count   = {count[31:16], 16'h0000};
                period_match = 1'b1;
            end else begin
                next_count = {count[31:16], count[15:0] + 16'h0001};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= `TMR_COUNT_RST;
        end else begin
            count <= next_count;
        end
    end

    // ------------------------------------------------------------
    // status and interrupt
    // ------------------------------------------------------------
    always_comb begin
        next_status = status;
        if (rd_done) begin
            next_status = status & ~read_status;
        end
        if (period_match) begin
            next_status[`TMR_ST_MATCH] = 1'b1;
        end
        if (gated_mode && count_enable && gate_fall) begin
            next_status[`TMR_ST_GATE_FALL] = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status    <= `TMR_STATUS_RST;
            timer_irq <= 1'b0;
        end else begin
            status    <= next_status;
            timer_irq <= |(next_status & next_mask);
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_pready_single: assert property (pready |=> !pready)
        else $error("pready held for more than one cycle");

    a_stopped_frozen: assert property ((!timer_run && !wr_count) |=> $stable(count))
        else $error("count moved while stopped");

    a_idle_frozen: assert property ((timer_run && idle_halt && device_idle && !wr_count) |=> $stable(count))
        else $error("count moved while idle halted");

    a_idle_counts: assert property ((timer_run && !idle_halt && device_idle && !clock_source_select &&
        !gate_accumulate_enable && psc_bus.select == PSC_DIV1 && wide_pair_mode && count != period &&
        !wr_count) |=> count == $past(count) + 32'h0000_0001)
        else $error("count stalled in idle without halt");

    a_ext_ignores_gate: assert property ((count_enable && clock_source_select &&
        psc_bus.select == PSC_DIV1 && wide_pair_mode && ext_rise && count != period && !wr_count)
        |=> count == $past(count) + 32'h0000_0001)
        else $error("external edge not counted");

    a_match_wraps: assert property ((psc_bus.tick && wide_pair_mode && count == period && !wr_count)
        |=> count == 32'h0000_0000 && status[`TMR_ST_MATCH])
        else $error("period match did not wrap or flag");

    a_half_isolated: assert property ((!wide_pair_mode && !wr_count) |=> count[31:16] == $past(count[31:16]))
        else $error("upper half moved in split mode");

    a_gate_fall_flag: assert property ((gated_mode && count_enable && gate_fall) |=> status[`TMR_ST_GATE_FALL])
        else $error("gate falling edge not flagged");

    a_gate_low_hold: assert property ((gated_mode && !ext_sync && !wr_count) |=> $stable(count))
        else $error("count moved with gate low");

    a_irq_follows: assert property (timer_irq == |(status & mask))
        else $error("interrupt disagrees with status and mask");
endmodule

/* tb/ext_pin_model.sv */
// partner model: external count and gate source on the count pin
`timescale 1ns/10ps
module ext_pin_model (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       go,
    input  wire logic [9:0] n_pulses,
    input  wire logic       gate_level,
    output logic            ext_count_pin,
    output logic            busy
);
    logic [11:0] left;

    // ------------------------------------------------------------
    // pulse train, two clocks high and two low per pulse
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            left <= 12'h000;
        end else if (go) begin
            left <= {n_pulses, 2'b00};
        end else if (left != 12'h000) begin
            left <= left - 12'h001;
        end
    end

    assign busy = (left != 12'h000);
    // gate level shows outside a train
    assign ext_count_pin = busy ? left[1] : gate_level;
endmodule

/* tb/gated_timer_pair_control_tb.sv */
// self-checking bench for the gated timer control block
`timescale 1ns/10ps
`include "gated_timer_cfg.svh"
module gated_timer_pair_control_tb;
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        device_idle;
    logic        ext_count_pin;
    logic        timer_irq;
    logic        go;
    logic [9:0]  n_pulses;
    logic        gate_level;
    logic        busy;
    logic [31:0] rd;
    logic        err;
    int          n_errors;
    int          n_compared;
    int          ratio [4] = '{1, 8, 64, 256};

    gated_timer_pair_control u_gated_timer_pair_control (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .device_idle(device_idle), .ext_count_pin(ext_count_pin), .timer_irq(timer_irq));

    ext_pin_model u_ext_pin_model (
        .pclk(pclk), .presetn(presetn), .go(go), .n_pulses(n_pulses),
        .gate_level(gate_level), .ext_count_pin(ext_count_pin), .busy(busy));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    // ------------------------------------------------------------
    // bus, pin and compare tasks
    // ------------------------------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_in(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
        n_compared++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h to %h", $time, got, lo, hi);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    task automatic pulses(input logic [9:0] n);
        @(posedge pclk);
        n_pulses <= n;
        go       <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        @(posedge pclk);
        while (busy === 1'b1) @(posedge pclk);
        repeat (6) @(posedge pclk);
    endtask

    task automatic run_ext(input logic [15:0] ctrl, input logic [31:0] start, input logic [9:0] n,
                           input logic [31:0] exp);
        wr(`TMR_OFS_COUNT, start);
        wr(`TMR_OFS_CONTROL, {16'h0000, ctrl});
        pulses(n);
        rd_chk(`TMR_OFS_COUNT, exp);
        wr(`TMR_OFS_CONTROL, 32'h0000_0000);
    endtask

    task automatic report_and_stop;
        $display("errors %0d compared %0d", n_errors, n_compared);
        if (n_errors == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        presetn     = 1'b0;
        psel        = 1'b0;
        penable     = 1'b0;
        pwrite      = 1'b0;
        paddr       = 8'h00;
        pwdata      = 32'h0000_0000;
        device_idle = 1'b0;
        go          = 1'b0;
        n_pulses    = 10'h000;
        gate_level  = 1'b0;
        n_errors    = 0;
        n_compared  = 0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`TMR_OFS_CONTROL, 32'h0000_0000);
        rd_chk(`TMR_OFS_COUNT, 32'h0000_0000);
        rd_chk(`TMR_OFS_PERIOD, 32'hffff_ffff);
        rd_chk(`TMR_OFS_STATUS, 32'h0000_0000);
        rd_chk(`TMR_OFS_MASK, 32'h0000_0000);
        apb(1'b0, 8'h14, 32'h0000_0000);
        check({31'h0, err}, 32'h0000_0001);
        check(rd, 32'h0000_0000);
        wr(`TMR_OFS_CONTROL, 32'h0000_ffff);
        rd_chk(`TMR_OFS_CONTROL, 32'h0000_a07a);
        wr(`TMR_OFS_CONTROL, 32'h0000_0000);
        // one count short of a third tick, gate bit set on odd codes
        for (int i = 0; i < 4; i++) begin
            run_ext(16'h8002 | 16'(i << 4) | 16'((i % 2) << 6), 0, 10'(ratio[i] * 3 - 1), 2);
        end
        rd_chk(`TMR_OFS_STATUS, 32'h0000_0000);
        device_idle <= 1'b1;
        run_ext(16'ha002, 32'h0000_0000, 10'd4, 32'h0000_0000);
        run_ext(16'h8002, 32'h0000_0000, 10'd4, 32'h0000_0004);
        wr(`TMR_OFS_COUNT, 32'h0000_0000);
        wr(`TMR_OFS_CONTROL, 32'h0000_8008);
        repeat (10) @(posedge pclk);
        wr(`TMR_OFS_CONTROL, 32'h0000_0000);
        apb(1'b0, `TMR_OFS_COUNT, 32'h0000_0000);
        check_in(rd, 32'd12, 32'd14);
        device_idle <= 1'b0;
        run_ext(16'h804a, 32'h0005_fffe, 10'd4, 32'h0006_0002);
        run_ext(16'h8002, 32'h0005_fffe, 10'd4, 32'h0005_0002);
        rd_chk(`TMR_OFS_STATUS, 32'h0000_0001);
        wr(`TMR_OFS_PERIOD, 32'h0001_0001);
        run_ext(16'h800a, 32'h0000_ffff, 10'd4, 32'h0000_0001);
        wr(`TMR_OFS_PERIOD, 32'h0000_0003);
        run_ext(16'h8002, 32'h0000_0000, 10'd4, 32'h0000_0000);
        check({31'h0, timer_irq}, 32'h0000_0000);
        wr(`TMR_OFS_MASK, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        check({31'h0, timer_irq}, 32'h0000_0001);
        rd_chk(`TMR_OFS_STATUS, 32'h0000_0001);
        repeat (2) @(posedge pclk);
        check({31'h0, timer_irq}, 32'h0000_0000);
        wr(`TMR_OFS_PERIOD, 32'hffff_ffff);
        wr(`TMR_OFS_COUNT, 32'h0000_0000);
        wr(`TMR_OFS_CONTROL, 32'h0000_8040);
        repeat (10) @(posedge pclk);
        rd_chk(`TMR_OFS_COUNT, 32'h0000_0000);
        gate_level <= 1'b1;
        repeat (20) @(posedge pclk);
        gate_level <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, `TMR_OFS_COUNT, 32'h0000_0000);
        check_in(rd, 32'd19, 32'd21);
        rd_chk(`TMR_OFS_STATUS, 32'h0000_0002);
        wr(`TMR_OFS_COUNT, 32'h0000_0000);
        wr(`TMR_OFS_CONTROL, 32'h0000_8000);
        repeat (30) @(posedge pclk);
        wr(`TMR_OFS_CONTROL, 32'h0000_0000);
        apb(1'b0, `TMR_OFS_COUNT, 32'h0000_0000);
        check_in(rd, 32'd31, 32'd35);
        report_and_stop();
    end

    // cut a hang short
    initial begin
        #200us;
        n_errors++;
        report_and_stop();
    end
endmodule
